// [core/lsc_supply_ctrl.sv]
// Notes on behaviour
// - Converter clock is ten times tone frequency.
// - Tone follows gate pin when not forced.
// - Forced tone runs continuously, gate pin ignored.
// - Cleared on bit disables that channel only.
// - Voltage select chooses low or high output.
// - Cable boost bit adds one volt.
// - Current range bit picks overcurrent threshold.
// - Dynamic overload cuts output, sets flag.
// - After off period, retry with clamped current.
// - Repeat on overload, else resume, clear flag.
// - Static mode flag follows overload sense.
// - Overload flags low after power-on start.
// - Overheat stops outputs, flag follows indication.
// - Overheat clears host-written control bits.
// - Force pin selects high voltage output.
// - Lockout holds switch drives low.
// - Both system registers reset to zero.
// - No bus acknowledge without power good.
`timescale 1ns/1ns
`default_nettype none
module lsc_supply_ctrl #(
  parameter int OFF_CYCLES = lsc_pkg::OFF_OSC_CYCLES,
  parameter int ON_CYCLES  = lsc_pkg::ON_OSC_CYCLES
) (
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Supervisory inputs.
  input  wire logic        power_good,
  input  wire logic        overheat_sense,
  input  wire logic [1:0]  overload_sense,
  // Control pins.
  input  wire logic [1:0]  tone_gate_pin,
  input  wire logic [1:0]  force_high_voltage_pin,
  // Channel controls to the analog stages.
  output logic      [1:0]  channel_on,
  output logic      [1:0]  high_voltage_out,
  output logic      [1:0]  cable_boost_out,
  output logic      [1:0]  current_range_out,
  output logic      [1:0]  current_clamp_out,
  output logic      [1:0]  tone_out,
  output logic      [1:0]  switch_drive_out
);
  import lsc_pkg::*;

  localparam logic [OSC_CNT_W-1:0]  OSC_LAST  = OSC_CNT_W'(OSC_HALF_CYCLES - 1);
  localparam logic [TONE_CNT_W-1:0] TONE_LAST = TONE_CNT_W'(TONE_HALF_OSC - 1);

  // Oscillator state.
  logic [OSC_CNT_W-1:0]  osc_count;
  logic [OSC_CNT_W-1:0]  next_osc_count;
  logic                  switch_clk;
  logic                  next_switch_clk;
  logic [TONE_CNT_W-1:0] tone_count;
  logic [TONE_CNT_W-1:0] next_tone_count;
  logic                  tone_wave;
  logic                  next_tone_wave;
  logic                  osc_tick;

  // Host-written control bits, index 0 is channel A.
  logic                  static_limit;
  logic                  next_static_limit;
  logic [1:0]            current_range;
  logic [1:0]            next_current_range;
  logic [1:0]            tone_force;
  logic [1:0]            next_tone_force;
  logic [1:0]            cable_boost;
  logic [1:0]            next_cable_boost;
  logic [1:0]            high_voltage_select;
  logic [1:0]            next_high_voltage_select;
  logic [1:0]            chan_enable;
  logic [1:0]            next_chan_enable;

  // Status and bus state.
  logic                  overheat_flag;
  logic                  next_overheat_flag;
  logic [1:0]            overload_flag;
  logic [1:0]            limit_on;
  logic [1:0]            limit_clamp;
  logic [1:0]            limit_active;
  logic                  next_ack;
  logic [31:0]           next_dat;
  logic                  write_strobe;
  logic [7:0]            system_register_a;
  logic [7:0]            system_register_b;

  // Outputs before registering.
  logic [1:0]            next_channel_on;
  logic [1:0]            next_high_voltage_out;
  logic [1:0]            next_cable_boost_out;
  logic [1:0]            next_current_range_out;
  logic [1:0]            next_current_clamp_out;
  logic [1:0]            next_tone_out;
  logic [1:0]            next_switch_drive_out;

  always_comb begin
    next_osc_count  = osc_count + 1'b1;
    next_switch_clk = switch_clk;
    next_tone_count = tone_count;
    next_tone_wave  = tone_wave;
    osc_tick        = 1'b0;
    if (osc_count == OSC_LAST) begin
      next_osc_count  = '0;
      next_switch_clk = !switch_clk;
      osc_tick        = !switch_clk;
      if (!switch_clk) begin
        if (tone_count == TONE_LAST) begin
          next_tone_count = '0;
          next_tone_wave  = !tone_wave;
        end else begin
          next_tone_count = tone_count + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      osc_count  <= '0;
      switch_clk <= 1'b0;
      tone_count <= '0;
      tone_wave  <= 1'b0;
    end else begin
      osc_count  <= next_osc_count;
      switch_clk <= next_switch_clk;
      tone_count <= next_tone_count;
      tone_wave  <= next_tone_wave;
    end
  end

  // Writes land on the edge that samples the acknowledge, so each request writes once.
  assign write_strobe = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];

  always_comb begin
    system_register_a = SYSREG_RESET;
    system_register_a[A_STATIC_LIMIT_POS]  = static_limit;
    system_register_a[A_CURRENT_RANGE_POS] = current_range[0];
    system_register_a[A_TONE_FORCE_POS]    = tone_force[0];
    system_register_a[A_CABLE_BOOST_POS]   = cable_boost[0];
    system_register_a[A_HIGH_VOLT_POS]     = high_voltage_select[0];
    system_register_a[A_ON_POS]            = chan_enable[0];
    system_register_a[A_OVERLOAD_POS]      = overload_flag[0];
    system_register_b = SYSREG_RESET;
    system_register_b[B_CURRENT_RANGE_POS] = current_range[1];
    system_register_b[B_TONE_FORCE_POS]    = tone_force[1];
    system_register_b[B_CABLE_BOOST_POS]   = cable_boost[1];
    system_register_b[B_HIGH_VOLT_POS]     = high_voltage_select[1];
    system_register_b[B_ON_POS]            = chan_enable[1];
    system_register_b[B_OVERHEAT_POS]      = overheat_flag;
    system_register_b[B_OVERLOAD_POS]      = overload_flag[1];
  end

  always_comb begin
    next_static_limit        = static_limit;
    next_current_range       = current_range;
    next_tone_force          = tone_force;
    next_cable_boost         = cable_boost;
    next_high_voltage_select = high_voltage_select;
    next_chan_enable         = chan_enable;
    next_overheat_flag       = overheat_sense;
    next_ack                 = wb_cyc_i && wb_stb_i && !wb_ack_o && power_good;
    next_dat                 = wb_dat_o;
    if (next_ack) begin
      if (wb_adr_i == SYSREG_A_ADDR) begin
        next_dat = {24'h00_0000, system_register_a};
      end else if (wb_adr_i == SYSREG_B_ADDR) begin
        next_dat = {24'h00_0000, system_register_b};
      end else begin
        next_dat = 32'h0000_0000;
      end
    end
    if (write_strobe && wb_adr_i == SYSREG_A_ADDR) begin
      next_static_limit        = wb_dat_i[A_STATIC_LIMIT_POS];
      next_current_range[0]    = wb_dat_i[A_CURRENT_RANGE_POS];
      next_tone_force[0]       = wb_dat_i[A_TONE_FORCE_POS];
      next_cable_boost[0]      = wb_dat_i[A_CABLE_BOOST_POS];
      next_high_voltage_select[0] = wb_dat_i[A_HIGH_VOLT_POS];
      next_chan_enable[0]      = wb_dat_i[A_ON_POS];
    end else if (write_strobe && wb_adr_i == SYSREG_B_ADDR) begin
      next_current_range[1]    = wb_dat_i[B_CURRENT_RANGE_POS];
      next_tone_force[1]       = wb_dat_i[B_TONE_FORCE_POS];
      next_cable_boost[1]      = wb_dat_i[B_CABLE_BOOST_POS];
      next_high_voltage_select[1] = wb_dat_i[B_HIGH_VOLT_POS];
      next_chan_enable[1]      = wb_dat_i[B_ON_POS];
    end
    if (overheat_flag || !power_good) begin
      next_static_limit        = 1'b0;
      next_current_range       = 2'b00;
      next_tone_force          = 2'b00;
      next_cable_boost         = 2'b00;
      next_high_voltage_select = 2'b00;
      next_chan_enable         = 2'b00;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      static_limit        <= 1'b0;
      current_range       <= 2'b00;
      tone_force          <= 2'b00;
      cable_boost         <= 2'b00;
      high_voltage_select <= 2'b00;
      chan_enable         <= 2'b00;
      overheat_flag       <= 1'b0;
      wb_ack_o            <= 1'b0;
      wb_dat_o            <= 32'h0000_0000;
    end else begin
      static_limit        <= next_static_limit;
      current_range       <= next_current_range;
      tone_force          <= next_tone_force;
      cable_boost         <= next_cable_boost;
      high_voltage_select <= next_high_voltage_select;
      chan_enable         <= next_chan_enable;
      overheat_flag       <= next_overheat_flag;
      wb_ack_o            <= next_ack;
      wb_dat_o            <= next_dat;
    end
  end

  assign limit_active = chan_enable & {2{power_good && !overheat_flag}};

  generate
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      lsc_limiter #(
        .OFF_CYCLES (OFF_CYCLES),
        .ON_CYCLES  (ON_CYCLES)
      ) u_limiter (
        .clock          (clock),
        .rst_n          (rst_n),
        .osc_tick       (osc_tick),
        .active         (limit_active[ch]),
        .static_mode    (static_limit),
        .overload_sense (overload_sense[ch]),
        .output_on      (limit_on[ch]),
        .clamp          (limit_clamp[ch]),
        .overload_flag  (overload_flag[ch])
      );
    end
  endgenerate

  always_comb begin
    next_channel_on        = limit_on & {2{!overheat_flag}};
    next_high_voltage_out  = (high_voltage_select | force_high_voltage_pin) & next_channel_on;
    next_cable_boost_out   = cable_boost & next_channel_on & ~force_high_voltage_pin;
    next_current_range_out = current_range;
    next_current_clamp_out = limit_clamp | {2{static_limit}};
    next_tone_out          = (tone_force | tone_gate_pin) & {2{tone_wave}} & next_channel_on;
    next_switch_drive_out  = {2{switch_clk && power_good}} & next_channel_on;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      channel_on        <= 2'b00;
      high_voltage_out  <= 2'b00;
      cable_boost_out   <= 2'b00;
      current_range_out <= 2'b00;
      current_clamp_out <= 2'b00;
      tone_out          <= 2'b00;
      switch_drive_out  <= 2'b00;
    end else begin
      channel_on        <= next_channel_on;
      high_voltage_out  <= next_high_voltage_out;
      cable_boost_out   <= next_cable_boost_out;
      current_range_out <= next_current_range_out;
      current_clamp_out <= next_current_clamp_out;
      tone_out          <= next_tone_out;
      switch_drive_out  <= next_switch_drive_out;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_tone_forced: assert property (tone_force[0] && next_channel_on[0] && tone_wave
                                  |=> tone_out[0])
    else $error("Forced tone missing on channel A.");
  a_tone_gated: assert property (!tone_force[1] && !tone_gate_pin[1] |=> !tone_out[1])
    else $error("Tone present with gate pin low on channel B.");
  a_force_high: assert property (force_high_voltage_pin[0] && next_channel_on[0]
                                 |=> high_voltage_out[0] && !cable_boost_out[0])
    else $error("Force pin did not select high voltage.");
  a_lockout_drive: assert property (!power_good |=> switch_drive_out == 2'b00)
    else $error("Switch drive active during lockout.");
  a_no_ack_lockout: assert property (!power_good |=> !wb_ack_o)
    else $error("Acknowledge given without power good.");
  a_overheat_wipe: assert property (overheat_flag |=> chan_enable == 2'b00 && tone_force == 2'b00)
    else $error("Controls not cleared under overheat.");
  a_channel_off: assert property (!chan_enable[1] |=> !channel_on[1] && !switch_drive_out[1])
    else $error("Disabled channel still running.");
  a_tone_ratio: assert property ($rose(tone_wave) |-> $past(osc_tick) && tone_count == 0)
    else $error("Tone edge not locked to oscillator.");
endmodule
`default_nettype wire

// [core/lsc_pkg.sv]
`default_nettype none
package lsc_pkg;

  // Clock and oscillator timing.
  localparam int CLK_KHZ          = 100000;
  localparam int OSC_KHZ          = 220;
  localparam int TONE_DIV         = 10;
  localparam int OSC_HALF_CYCLES  = CLK_KHZ / (2 * OSC_KHZ);
  localparam int TONE_HALF_OSC    = TONE_DIV / 2;
  localparam int OSC_CNT_W        = 8;
  localparam int TONE_CNT_W       = 3;

  // Dynamic limiting periods, counted in oscillator cycles.
  localparam int T_OFF_MS         = 900;
  localparam int T_ON_MS          = 20;
  localparam int OFF_OSC_CYCLES   = T_OFF_MS * OSC_KHZ;
  localparam int ON_OSC_CYCLES    = T_ON_MS * OSC_KHZ;
  localparam int LIMIT_CNT_W      = 18;

  // Register map.
  localparam logic [3:0] SYSREG_A_ADDR = 4'h0;
  localparam logic [3:0] SYSREG_B_ADDR = 4'h4;
  localparam logic [7:0] SYSREG_RESET  = 8'h00;

  // Field positions of the first system register.
  localparam int A_STATIC_LIMIT_POS  = 6;
  localparam int A_CURRENT_RANGE_POS = 5;
  localparam int A_TONE_FORCE_POS    = 4;
  localparam int A_CABLE_BOOST_POS   = 3;
  localparam int A_HIGH_VOLT_POS     = 2;
  localparam int A_ON_POS            = 1;
  localparam int A_OVERLOAD_POS      = 0;

  // Field positions of the second system register.
  localparam int B_CURRENT_RANGE_POS = 6;
  localparam int B_TONE_FORCE_POS    = 5;
  localparam int B_CABLE_BOOST_POS   = 4;
  localparam int B_HIGH_VOLT_POS     = 3;
  localparam int B_ON_POS            = 2;
  localparam int B_OVERHEAT_POS      = 1;
  localparam int B_OVERLOAD_POS      = 0;

  typedef enum logic [1:0] {
    LSC_NORMAL = 2'b00,
    LSC_OFF    = 2'b01,
    LSC_ON     = 2'b10
  } lsc_limit_state_type;

endpackage
`default_nettype wire

// [core/lsc_limiter.sv]
`timescale 1ns/1ns
`default_nettype none
module lsc_limiter #(
  parameter int OFF_CYCLES = lsc_pkg::OFF_OSC_CYCLES,
  parameter int ON_CYCLES  = lsc_pkg::ON_OSC_CYCLES
) (
  // Clock and reset.
  input  wire logic clock,
  input  wire logic rst_n,
  // Controls.
  input  wire logic osc_tick,
  input  wire logic active,
  input  wire logic static_mode,
  input  wire logic overload_sense,
  // Results.
  output logic      output_on,
  output logic      clamp,
  output logic      overload_flag
);
  import lsc_pkg::*;

  lsc_limit_state_type      state;
  lsc_limit_state_type      next_state;
  logic [LIMIT_CNT_W-1:0]   count;
  logic [LIMIT_CNT_W-1:0]   next_count;
  logic                     seen;
  logic                     next_seen;
  logic                     next_flag;

  localparam logic [LIMIT_CNT_W-1:0] OFF_LAST = LIMIT_CNT_W'(OFF_CYCLES - 1);
  localparam logic [LIMIT_CNT_W-1:0] ON_LAST  = LIMIT_CNT_W'(ON_CYCLES - 1);

  always_comb begin
    next_state = state;
    next_count = count;
    next_seen  = seen;
    next_flag  = overload_flag;
    if (!active) begin
      // A disabled channel holds no overload history.
      next_state = LSC_NORMAL;
      next_count = '0;
      next_seen  = 1'b0;
      next_flag  = 1'b0;
    end else begin
      case (state)
        LSC_NORMAL: begin
          if (static_mode) begin
            next_flag = overload_sense;
          end else if (overload_sense) begin
            next_state = LSC_OFF;
            next_count = '0;
            next_flag  = 1'b1;
          end else begin
            next_flag = 1'b0;
          end
        end
        LSC_OFF: begin
          if (osc_tick) begin
            if (count == OFF_LAST) begin
              next_state = LSC_ON;
              next_count = '0;
              next_seen  = 1'b0;
            end else begin
              next_count = count + 1'b1;
            end
          end
        end
        LSC_ON: begin
          if (overload_sense) begin
            next_seen = 1'b1;
          end
          if (osc_tick && count == ON_LAST) begin
            next_count = '0;
            if (seen || overload_sense) begin
              next_state = LSC_OFF;
            end else begin
              next_state = LSC_NORMAL;
              next_flag  = 1'b0;
            end
          end else if (osc_tick) begin
            next_count = count + 1'b1;
          end
        end
        default: begin
          next_state = LSC_NORMAL;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state         <= LSC_NORMAL;
      count         <= '0;
      seen          <= 1'b0;
      overload_flag <= 1'b0;
    end else begin
      state         <= next_state;
      count         <= next_count;
      seen          <= next_seen;
      overload_flag <= next_flag;
    end
  end

  // The output is cut while the channel is inactive or the retry timer runs its off period.
  assign output_on = active && (state != LSC_OFF);
  assign clamp     = (state == LSC_ON);

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_trip;
    active && !static_mode && state == LSC_NORMAL && overload_sense;
  endsequence

  a_trip_sets_flag: assert property (s_trip |=> state == LSC_OFF && overload_flag)
    else $error("Dynamic overload did not cut output and set flag.");
  a_off_output_low: assert property (state == LSC_OFF |-> !output_on && overload_flag)
    else $error("Output on or flag low during off period.");
  a_static_follow: assert property (active && static_mode && state == LSC_NORMAL
                                    |=> overload_flag == $past(overload_sense))
    else $error("Static overload flag does not follow sense.");
  a_clean_on_clears: assert property (state == LSC_ON && osc_tick && count == ON_LAST && !seen
                                      && !overload_sense && active |=> state == LSC_NORMAL
                                      && !overload_flag)
    else $error("Clean on period did not resume normal operation.");
endmodule
`default_nettype wire

// [test/lsc_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
module lsc_host_model (
  // Clock.
  input  wire logic        clock,
  // Answer from the slave.
  input  wire logic        wb_ack_o,
  input  wire logic [31:0] wb_dat_o,
  // Request to the slave.
  output logic             wb_cyc_i,
  output logic             wb_stb_i,
  output logic             wb_we_i,
  output logic      [3:0]  wb_adr_i,
  output logic      [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_i
);
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'b000;
    wb_adr_i = 4'hf;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0000_0000;
  end
  // A lost answer returns ok low, so a refusal can be judged by the caller.
  task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d, input int lim,
                      output logic [31:0] q, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    q = 32'h0000_0000;
    @(posedge clock);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
    wb_adr_i <= a;
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h00_0000, d};
    while (!ok && n < lim) begin
      @(posedge clock);
      n++;
      if (wb_ack_o === 1'b1) begin
        ok = 1'b1;
        q = wb_dat_o;
      end
    end
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    // Idle lines change, so a stale value never passes for a live one.
    wb_adr_i <= ~a;
    wb_dat_i <= ~{24'h00_0000, d};
  endtask
endmodule
`default_nettype wire

// [test/lsc_supply_ctrl_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module lsc_supply_ctrl_tb_top;
  import lsc_pkg::*;
  logic clock, rst_n, cyc, stb, we, ack, power_good, overheat_sense;
  logic [3:0] adr, sel;
  logic [31:0] wdat, rdat, q;
  logic [1:0] overload_sense, tone_gate_pin, force_pin, channel_on, hv, boost, range, clamp, tone_out, sw;
  logic ok;
  int bad_count, samples_checked, n, te, sr;
  lsc_supply_ctrl #(.OFF_CYCLES(4), .ON_CYCLES(3)) i_dut (.clock(clock), .rst_n(rst_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .power_good(power_good), .overheat_sense(overheat_sense),
    .overload_sense(overload_sense), .tone_gate_pin(tone_gate_pin), .force_high_voltage_pin(force_pin),
    .channel_on(channel_on), .high_voltage_out(hv), .cable_boost_out(boost), .current_range_out(range),
    .current_clamp_out(clamp), .tone_out(tone_out), .switch_drive_out(sw));
  lsc_host_model i_host (.clock(clock), .wb_ack_o(ack), .wb_dat_o(rdat), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clock);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    i_host.xfer(1'b1, a, d, 50, q, ok);
    chk({31'h0, ok}, 32'h1);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    i_host.xfer(1'b0, a, 8'h00, 50, q, ok);
    chk({31'h0, ok}, 32'h1);
    chk(q, {24'h00_0000, e});
  endtask
  task automatic wait_on(input logic v, input int lim);
    n = 0;
    while (channel_on[0] !== v && n < lim) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n >= lim) begin
      bad_count++;
      $display("ERROR at %0t: wait limit reached", $time);
      close_out();
    end
  endtask
  task automatic measure(input int lim);
    logic pt, ps;
    te = 0;
    sr = 0;
    pt = tone_out[0];
    ps = sw[0];
    repeat (lim) begin
      @(posedge clock);
      #1;
      if (tone_out[0] !== pt) te++;
      if (sw[0] === 1'b1 && ps === 1'b0) sr++;
      pt = tone_out[0];
      ps = sw[0];
    end
  endtask
  task automatic t_reset;
    rd(SYSREG_A_ADDR, 8'h00);
    rd(SYSREG_B_ADDR, 8'h00);
    wr(4'h8, 8'hff);
    rd(4'h8, 8'h00);
    rd(SYSREG_A_ADDR, 8'h00);
  endtask
  task automatic t_levels;
    wr(SYSREG_A_ADDR, 8'h2e);
    tick(2);
    #1;
    chk(channel_on, 2'b01);
    chk(hv, 2'b01);
    chk(boost, 2'b01);
    chk(range, 2'b01);
    rd(SYSREG_A_ADDR, 8'h2e);
    wr(SYSREG_A_ADDR, 8'h0a);
    wr(SYSREG_B_ADDR, 8'h04);
    tick(1);
    force_pin <= 2'b01;
    tick(2);
    #1;
    chk(hv, 2'b01);
    chk(boost, 2'b00);
    tick(1);
    force_pin <= 2'b00;
    tick(2);
    #1;
    chk(hv, 2'b00);
    chk(boost, 2'b01);
  endtask
  task automatic t_tone;
    measure(5000);
    chk(te, 0);
    chk(tone_out, 2'b00);
    tick(1);
    tone_gate_pin <= 2'b01;
    tick(20);
    #1;
    measure(4540);
    chk(te, 2);
    chk(sr, 10);
    tick(1);
    tone_gate_pin <= 2'b00;
    wr(SYSREG_A_ADDR, 8'h1a);
    tick(20);
    #1;
    measure(4540);
    chk(te, 2);
  endtask
  task automatic t_overload;
    wr(SYSREG_A_ADDR, 8'h42);
    tick(1);
    overload_sense <= 2'b01;
    tick(3);
    #1;
    chk(clamp[0], 1'b1);
    rd(SYSREG_A_ADDR, 8'h43);
    overload_sense <= 2'b00;
    tick(3);
    rd(SYSREG_A_ADDR, 8'h42);
    wr(SYSREG_A_ADDR, 8'h02);
    tick(1);
    overload_sense <= 2'b01;
    tick(2);
    overload_sense <= 2'b00;
    #1;
    wait_on(1'b0, 6);
    rd(SYSREG_A_ADDR, 8'h03);
    wait_on(1'b1, 3000);
    chk(n >= 1300 && n <= 1820, 1);
    tick(2);
    #1;
    chk(clamp[0], 1'b1);
    tick(1);
    overload_sense <= 2'b01;
    tick(2);
    overload_sense <= 2'b00;
    #1;
    // The output stays on until the on period ends, then the retry repeats.
    wait_on(1'b0, 1500);
    wait_on(1'b1, 3000);
    tick(1500);
    #1;
    chk(clamp[0], 1'b0);
    chk(channel_on[0], 1'b1);
    rd(SYSREG_A_ADDR, 8'h02);
  endtask
  task automatic t_overheat;
    wr(SYSREG_B_ADDR, 8'h44);
    tick(1);
    overheat_sense <= 1'b1;
    tick(3);
    #1;
    chk(channel_on, 2'b00);
    rd(SYSREG_B_ADDR, 8'h02);
    wr(SYSREG_A_ADDR, 8'h02);
    rd(SYSREG_A_ADDR, 8'h00);
    overheat_sense <= 1'b0;
    tick(3);
    rd(SYSREG_B_ADDR, 8'h00);
    wr(SYSREG_B_ADDR, 8'h04);
    tick(2);
    #1;
    chk(channel_on, 2'b10);
  endtask
  task automatic t_lockout;
    wr(SYSREG_A_ADDR, 8'h02);
    tick(1);
    power_good <= 1'b0;
    tick(3);
    #1;
    measure(1000);
    chk(sr, 0);
    chk(sw, 2'b00);
    i_host.xfer(1'b0, SYSREG_A_ADDR, 8'h00, 20, q, ok);
    chk({31'h0, ok}, 32'h0);
    tick(1);
    power_good <= 1'b1;
    tick(2);
    rd(SYSREG_A_ADDR, 8'h00);
  endtask
  initial begin
    #600_000;
    bad_count++;
    close_out();
  end
  initial begin
    rst_n = 1'b0;
    power_good = 1'b1;
    overheat_sense = 1'b0;
    overload_sense = 2'b00;
    tone_gate_pin = 2'b00;
    force_pin = 2'b00;
    bad_count = 0;
    samples_checked = 0;
    tick(20);
    rst_n <= 1'b1;
    t_reset();
    t_levels();
    t_tone();
    t_overload();
    t_overheat();
    t_lockout();
    close_out();
  end
endmodule
`default_nettype wire
